// >>> analog_output_param_control.sv
// Operation
// - Each channel accepts unused, 0-10 V, +-10 V, 0-20 mA or 4-20 mA.
// - Unused channels are skipped by the scan, no conversion.
// - Unused channels use the 0-10 V circuit and drive 0 V.
// - Data type is plain binary or a user optional range.
// - Binary range 0..4095, or -2048..2047 for bipolar voltage.
// - User min/max writable only in optional range, within 16-bit signed.
// - Data outside the allowed range raises a parameter setting error.
// - Output data moves through the data registers at each scan end while running and not initializing.
// - Stopped with hold flag set, each channel keeps its last value.
// - Stopped without hold, drive minimum output; bipolar drives zero volts.
// - Status: 0 normal, 2 initializing, 3 parameter error, 4 supply fault.
// - Output is unguaranteed whenever status is nonzero.
// - Block of words from base register; length depends on register parameters.
// - Without register parameters, first scan after run loads initial parameters.
// - With register parameters, mode, type, min and max sit in registers.
// - With register parameters, stop-to-run applies the operation setting registers.
// - Program update or checksum error copies initial set into setting registers.
// - Control bit +0 rising copies current settings into setting registers.
// - Control bit +1 rising loads the saved initial set into setting registers.
// - Control bit +2 rising applies setting registers at that scan end.
// - Each control bit clears itself after its rising edge is handled.
// - All three rising together run in order +0, +1, +2.
module analog_output_param_control
	import ao_param_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic run_i,
	input wire logic scan_end_i,
	input wire logic hold_outputs_when_stopped_flag_i,
	input wire logic use_reg_params_i,
	input wire logic user_prog_update_i,
	input wire logic keep_sum_err_i,
	input wire logic supply_fault_i,
	input wire logic [2:0] ctl_relay_i,
	output logic [2:0] ctl_relay_clr_o,
	input wire logic [3:0] dreg_addr_i,
	input wire logic dreg_wr_i,
	input wire logic [15:0] dreg_wdata_i,
	output logic [15:0] dreg_rdata_o,
	output logic [3:0] words_used_o,
	input wire logic [NUM_CH-1:0][2:0] init_sig_i,
	input wire logic [NUM_CH-1:0] init_dt_i,
	input wire logic [NUM_CH-1:0][15:0] init_min_i,
	input wire logic [NUM_CH-1:0][15:0] init_max_i,
	output logic [NUM_CH-1:0][15:0] ao_value_o,
	output logic [NUM_CH-1:0][2:0] ao_range_o,
	output logic [NUM_CH-1:0] ao_conv_en_o
);

	typedef enum logic [1:0] {
		ST_READY = 2'b01,
		ST_INIT = 2'b10
	} seq_state_t;

	function automatic logic word_ch(input logic [3:0] a);
		logic [3:0] rel;
		rel = a - PARAM_BASE;
		return (a < PARAM_BASE) ? a[1] : rel[2];
	endfunction

	function automatic logic [1:0] word_fld(input logic [3:0] a);
		logic [3:0] rel;
		rel = a - PARAM_BASE;
		return rel[1:0];
	endfunction

	logic [2:0] osr_sig_r [NUM_CH];
	logic [2:0] osr_sig_nxt [NUM_CH];
	logic osr_dt_r [NUM_CH];
	logic osr_dt_nxt [NUM_CH];
	logic [15:0] osr_min_r [NUM_CH];
	logic [15:0] osr_min_nxt [NUM_CH];
	logic [15:0] osr_max_r [NUM_CH];
	logic [15:0] osr_max_nxt [NUM_CH];
	logic [2:0] act_sig_r [NUM_CH];
	logic [2:0] act_sig_nxt [NUM_CH];
	logic act_dt_r [NUM_CH];
	logic act_dt_nxt [NUM_CH];
	logic [15:0] act_min_r [NUM_CH];
	logic [15:0] act_min_nxt [NUM_CH];
	logic [15:0] act_max_r [NUM_CH];
	logic [15:0] act_max_nxt [NUM_CH];
	logic [15:0] data_r [NUM_CH];
	logic [15:0] data_nxt [NUM_CH];
	logic [15:0] ch_status [NUM_CH];

	seq_state_t state_r;
	seq_state_t state_nxt;
	logic [7:0] init_cnt_r;
	logic [7:0] init_cnt_nxt;
	logic pend_r;
	logic pend_nxt;
	logic run_prev_r;
	logic [2:0] ctl_prev_r;
	logic [2:0] ctl_prev_nxt;
	logic [2:0] ctl_rise;
	logic [2:0] clr_nxt;
	logic fault_meta_r;
	logic fault_sync_r;
	logic [15:0] rdata_nxt;
	logic [3:0] words_nxt;
	logic load_init;
	logic load_osr;
	logic apply;
	logic wch;
	logic [1:0] wfld;

	assign wch = word_ch(dreg_addr_i);
	assign wfld = word_fld(dreg_addr_i);
	assign apply = scan_end_i && run_i && (state_r == ST_READY);
	// Relays act only with register parameters; an acted bit counts as cleared for the next edge
	assign ctl_rise = (scan_end_i && use_reg_params_i) ? (ctl_relay_i & ~ctl_prev_r) : 3'h0;
	assign load_init = scan_end_i && pend_r && !use_reg_params_i;
	assign load_osr = scan_end_i && use_reg_params_i && (pend_r || ctl_rise[CTL_WRITE_PARAMS]);

	// Parameter store: software writes, then relay copies, then the download copy wins
	always_comb
	begin
		osr_sig_nxt = osr_sig_r;
		osr_dt_nxt = osr_dt_r;
		osr_min_nxt = osr_min_r;
		osr_max_nxt = osr_max_r;
		act_sig_nxt = act_sig_r;
		act_dt_nxt = act_dt_r;
		act_min_nxt = act_min_r;
		act_max_nxt = act_max_r;
		data_nxt = data_r;
		if (dreg_wr_i)
		begin
			if (dreg_addr_i < PARAM_BASE)
			begin
				if (!dreg_addr_i[0])
					data_nxt[wch] = dreg_wdata_i;
			end
			else if (use_reg_params_i && dreg_addr_i < WORDS_REG_ON)
			begin
				case (wfld)
					FLD_SIG: osr_sig_nxt[wch] = dreg_wdata_i[2:0];
					FLD_DT: osr_dt_nxt[wch] = dreg_wdata_i[0];
					FLD_MIN:
					begin
						if (osr_dt_r[wch] == DT_OPTIONAL)
							osr_min_nxt[wch] = dreg_wdata_i;
					end
					FLD_MAX:
					begin
						if (osr_dt_r[wch] == DT_OPTIONAL)
							osr_max_nxt[wch] = dreg_wdata_i;
					end
					default: osr_sig_nxt[wch] = osr_sig_r[wch];
				endcase
			end
		end
		for (int i = 0; i < NUM_CH; i++)
		begin
			if (ctl_rise[CTL_READ_PARAMS])
			begin
				osr_sig_nxt[i] = act_sig_r[i];
				osr_dt_nxt[i] = act_dt_r[i];
				osr_min_nxt[i] = act_min_r[i];
				osr_max_nxt[i] = act_max_r[i];
			end
			if (ctl_rise[CTL_READ_INIT] || user_prog_update_i || keep_sum_err_i)
			begin
				osr_sig_nxt[i] = init_sig_i[i];
				osr_dt_nxt[i] = init_dt_i[i];
				osr_min_nxt[i] = init_min_i[i];
				osr_max_nxt[i] = init_max_i[i];
			end
			if (load_init)
			begin
				act_sig_nxt[i] = init_sig_i[i];
				act_dt_nxt[i] = init_dt_i[i];
				act_min_nxt[i] = init_min_i[i];
				act_max_nxt[i] = init_max_i[i];
			end
			else if (load_osr)
			begin
				act_sig_nxt[i] = osr_sig_nxt[i];
				act_dt_nxt[i] = osr_dt_nxt[i];
				act_min_nxt[i] = osr_min_nxt[i];
				act_max_nxt[i] = osr_max_nxt[i];
			end
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			for (int i = 0; i < NUM_CH; i++)
			begin
				osr_sig_r[i] <= RST_SIG;
				osr_dt_r[i] <= RST_DT;
				osr_min_r[i] <= RST_WORD;
				osr_max_r[i] <= RST_WORD;
				act_sig_r[i] <= RST_SIG;
				act_dt_r[i] <= RST_DT;
				act_min_r[i] <= RST_WORD;
				act_max_r[i] <= RST_WORD;
				data_r[i] <= RST_WORD;
			end
		end
		else
		begin
			osr_sig_r <= osr_sig_nxt;
			osr_dt_r <= osr_dt_nxt;
			osr_min_r <= osr_min_nxt;
			osr_max_r <= osr_max_nxt;
			act_sig_r <= act_sig_nxt;
			act_dt_r <= act_dt_nxt;
			act_min_r <= act_min_nxt;
			act_max_r <= act_max_nxt;
			data_r <= data_nxt;
		end
	end

	// Sequencer, relay edges and register read port
	always_comb
	begin
		pend_nxt = pend_r;
		if (scan_end_i && pend_r)
			pend_nxt = 1'b0;
		if (run_i && !run_prev_r)
			pend_nxt = 1'b1;
		if (!run_i)
			pend_nxt = 1'b0;
		ctl_prev_nxt = scan_end_i ? (ctl_relay_i & ~ctl_rise) : ctl_prev_r;
		clr_nxt = ctl_rise;
		state_nxt = state_r;
		init_cnt_nxt = init_cnt_r;
		case (state_r)
			ST_READY:
			begin
				if (load_init || load_osr)
				begin
					state_nxt = ST_INIT;
					init_cnt_nxt = 8'h00;
				end
			end
			ST_INIT:
			begin
				init_cnt_nxt = init_cnt_r + 8'h01;
				if (load_init || load_osr)
					init_cnt_nxt = 8'h00;
				else if (init_cnt_r == INIT_CYCLES - 8'h01)
					state_nxt = ST_READY;
			end
			default:
			begin
				state_nxt = ST_READY;
				init_cnt_nxt = 8'h00;
			end
		endcase
		words_nxt = use_reg_params_i ? WORDS_REG_ON : WORDS_REG_OFF;
		rdata_nxt = 16'h0000;
		if (dreg_addr_i < PARAM_BASE)
			rdata_nxt = dreg_addr_i[0] ? ch_status[wch] : data_r[wch];
		else if (use_reg_params_i && dreg_addr_i < WORDS_REG_ON)
		begin
			case (wfld)
				FLD_SIG: rdata_nxt = {13'h0000, osr_sig_r[wch]};
				FLD_DT: rdata_nxt = {15'h0000, osr_dt_r[wch]};
				FLD_MIN: rdata_nxt = osr_min_r[wch];
				FLD_MAX: rdata_nxt = osr_max_r[wch];
				default: rdata_nxt = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			state_r <= ST_READY;
			init_cnt_r <= 8'h00;
			pend_r <= 1'b0;
			run_prev_r <= 1'b0;
			ctl_prev_r <= 3'h0;
			ctl_relay_clr_o <= 3'h0;
			fault_meta_r <= 1'b0;
			fault_sync_r <= 1'b0;
			dreg_rdata_o <= 16'h0000;
			words_used_o <= WORDS_REG_OFF;
		end
		else
		begin
			state_r <= state_nxt;
			init_cnt_r <= init_cnt_nxt;
			pend_r <= pend_nxt;
			run_prev_r <= run_i;
			ctl_prev_r <= ctl_prev_nxt;
			ctl_relay_clr_o <= clr_nxt;
			fault_meta_r <= supply_fault_i;
			fault_sync_r <= fault_meta_r;
			dreg_rdata_o <= rdata_nxt;
			words_used_o <= words_nxt;
		end
	end

	// Output value is only trusted while status reads zero
	for (genvar g = 0; g < NUM_CH; g++)
	begin : g_ch
		ao_channel u_ch (
			.clk_sys_i(clk_sys_i),
			.rst_n_i(rst_n_i),
			.sig_i(act_sig_r[g]),
			.dt_i(act_dt_r[g]),
			.min_i(act_min_r[g]),
			.max_i(act_max_r[g]),
			.data_i(data_r[g]),
			.apply_i(apply),
			.running_i(run_i),
			.hold_i(hold_outputs_when_stopped_flag_i),
			.init_busy_i(state_r == ST_INIT),
			.fault_i(fault_sync_r),
			.value_o(ao_value_o[g]),
			.range_o(ao_range_o[g]),
			.conv_en_o(ao_conv_en_o[g]),
			.status_o(ch_status[g])
		);
	end

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);

	AST_CTL_SELF_CLEAR: assert property (
		scan_end_i && use_reg_params_i && ctl_relay_i[0] && !ctl_prev_r[0] |=> ctl_relay_clr_o[0] ##1 !ctl_relay_clr_o[0])
		else $error("Control bit not cleared once");

	AST_ALL_THREE: assert property (
		scan_end_i && use_reg_params_i && (&(ctl_relay_i & ~ctl_prev_r))
		|=> act_sig_r[0] == $past(init_sig_i[0]) && act_min_r[0] == $past(init_min_i[0]) && state_r == ST_INIT)
		else $error("Simultaneous relays did not end on initial values");

	AST_RUN_INIT_LOAD: assert property (
		scan_end_i && pend_r && !use_reg_params_i
		|=> act_sig_r[0] == $past(init_sig_i[0]) && act_dt_r[0] == $past(init_dt_i[0]) && state_r == ST_INIT
		##1 ch_status[0] == STAT_INITIALIZING)
		else $error("Stop to run did not load initial parameters");

	AST_RUN_OSR_LOAD: assert property (
		scan_end_i && pend_r && use_reg_params_i && ctl_relay_i == 3'h0 && !dreg_wr_i && !user_prog_update_i && !keep_sum_err_i
		|=> act_max_r[1] == $past(osr_max_r[1]) && act_dt_r[1] == $past(osr_dt_r[1]))
		else $error("Stop to run did not apply setting registers");

	AST_PROG_COPY: assert property (
		user_prog_update_i || keep_sum_err_i |=> osr_sig_r[1] == $past(init_sig_i[1]) && osr_max_r[1] == $past(init_max_i[1]))
		else $error("Initial set not copied to setting registers");

	AST_MIN_LOCK: assert property (
		dreg_wr_i && use_reg_params_i && dreg_addr_i == PARAM_BASE + 4'h2 && osr_dt_r[0] == DT_BINARY && !scan_end_i
		&& !user_prog_update_i && !keep_sum_err_i |=> $stable(osr_min_r[0]))
		else $error("Minimum written in binary mode");

	AST_WORDS: assert property (
		use_reg_params_i ##1 use_reg_params_i |-> words_used_o == WORDS_REG_ON)
		else $error("Block length wrong");

	AST_INIT_ENDS: assert property (
		state_r == ST_INIT && init_cnt_r == INIT_CYCLES - 8'h01 && !load_init && !load_osr |=> state_r == ST_READY)
		else $error("Initializing did not finish");

	COV_RUN_START: cover property (run_i && !run_prev_r ##[1:20] scan_end_i && pend_r);
	COV_ALL_THREE: cover property (scan_end_i && use_reg_params_i && (&(ctl_relay_i & ~ctl_prev_r)));
	COV_PARAM_ERR: cover property (ch_status[0] == STAT_PARAM_ERR);
	COV_HOLD: cover property (!run_i && hold_outputs_when_stopped_flag_i && ao_conv_en_o[0]);

endmodule

// >>> ao_channel.sv
module ao_channel
	import ao_param_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [2:0] sig_i,
	input wire logic dt_i,
	input wire logic signed [15:0] min_i,
	input wire logic signed [15:0] max_i,
	input wire logic signed [15:0] data_i,
	input wire logic apply_i,
	input wire logic running_i,
	input wire logic hold_i,
	input wire logic init_busy_i,
	input wire logic fault_i,
	output logic signed [15:0] value_o,
	output logic [2:0] range_o,
	output logic conv_en_o,
	output logic [15:0] status_o
);

	logic err_r;
	logic err_nxt;
	logic signed [15:0] value_nxt;
	logic [2:0] range_nxt;
	logic conv_en_nxt;
	logic [15:0] status_nxt;
	logic signed [16:0] span_sum;
	logic signed [15:0] stop_value;

	always_comb
	begin
		span_sum = 17'(min_i) + 17'(max_i);
		// Zero volts sits mid-scale for a bipolar user range
		if (dt_i == DT_BINARY)
			stop_value = 16'sh0000;
		else if (sig_i == SIG_PM10V)
			stop_value = span_sum[16:1];
		else
			stop_value = min_i;
		err_nxt = init_busy_i ? 1'b0 : err_r;
		if (apply_i && !init_busy_i)
			err_nxt = !(cfg_ok(sig_i, dt_i, min_i, max_i) && value_ok(sig_i, dt_i, min_i, max_i, data_i));
		value_nxt = value_o;
		if (sig_i == SIG_UNUSED)
			value_nxt = 16'sh0000;
		else if (running_i)
		begin
			if (apply_i && !init_busy_i && !err_nxt)
				value_nxt = data_i;
		end
		else if (!hold_i)
			value_nxt = stop_value;
		// Hold case keeps the last driven value
		range_nxt = (sig_i == SIG_UNUSED) ? SIG_0_10V : sig_i;
		conv_en_nxt = (sig_i != SIG_UNUSED);
		if (init_busy_i)
			status_nxt = STAT_INITIALIZING;
		else if (fault_i)
			status_nxt = STAT_SUPPLY_FAULT;
		else if (err_nxt || !cfg_ok(sig_i, dt_i, min_i, max_i))
			status_nxt = STAT_PARAM_ERR;
		else
			status_nxt = STAT_OK;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			err_r <= 1'b0;
			value_o <= 16'sh0000;
			range_o <= SIG_0_10V;
			conv_en_o <= 1'b0;
			status_o <= STAT_OK;
		end
		else
		begin
			err_r <= err_nxt;
			value_o <= value_nxt;
			range_o <= range_nxt;
			conv_en_o <= conv_en_nxt;
			status_o <= status_nxt;
		end
	end

	AST_UNUSED_ZERO: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		sig_i == SIG_UNUSED |=> value_o == 16'sh0000 && !conv_en_o && range_o == SIG_0_10V)
		else $error("Unused channel not at zero volts");

	AST_PARAM_ERR: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		apply_i && !init_busy_i && !fault_i && !value_ok(sig_i, dt_i, min_i, max_i, data_i)
		|=> status_o == STAT_PARAM_ERR && value_o == $past(value_o))
		else $error("Out of range data not flagged");

	AST_HOLD_STOP: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		!running_i && hold_i && sig_i != SIG_UNUSED |=> value_o == $past(value_o))
		else $error("Held output changed while stopped");

	AST_BIP_STOP: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		!running_i && !hold_i && sig_i == SIG_PM10V && dt_i == DT_BINARY |=> value_o == 16'sh0000)
		else $error("Bipolar stop value not zero volts");

endmodule

// >>> ao_param_pkg.sv
package ao_param_pkg;

	localparam int NUM_CH = 2;
	localparam int DW = 16;

	localparam logic [2:0] SIG_UNUSED = 3'h0;
	localparam logic [2:0] SIG_0_10V = 3'h1;
	localparam logic [2:0] SIG_PM10V = 3'h2;
	localparam logic [2:0] SIG_0_20MA = 3'h3;
	localparam logic [2:0] SIG_4_20MA = 3'h4;

	localparam logic DT_BINARY = 1'b0;
	localparam logic DT_OPTIONAL = 1'b1;

	localparam logic signed [15:0] BIN_UNI_MIN = 16'sh0000;
	localparam logic signed [15:0] BIN_UNI_MAX = 16'sh0FFF;
	localparam logic signed [15:0] BIN_BIP_MIN = 16'shF800;
	localparam logic signed [15:0] BIN_BIP_MAX = 16'sh07FF;

	localparam logic [15:0] STAT_OK = 16'h0000;
	localparam logic [15:0] STAT_INITIALIZING = 16'h0002;
	localparam logic [15:0] STAT_PARAM_ERR = 16'h0003;
	localparam logic [15:0] STAT_SUPPLY_FAULT = 16'h0004;

	// Word map of the data register block
	localparam logic [3:0] PARAM_BASE = 4'h4;
	localparam logic [1:0] FLD_SIG = 2'h0;
	localparam logic [1:0] FLD_DT = 2'h1;
	localparam logic [1:0] FLD_MIN = 2'h2;
	localparam logic [1:0] FLD_MAX = 2'h3;
	localparam logic [3:0] WORDS_REG_OFF = 4'h4;
	localparam logic [3:0] WORDS_REG_ON = 4'hC;

	localparam int CTL_READ_PARAMS = 0;
	localparam int CTL_READ_INIT = 1;
	localparam int CTL_WRITE_PARAMS = 2;

	localparam logic [2:0] RST_SIG = SIG_UNUSED;
	localparam logic RST_DT = DT_BINARY;
	localparam logic [15:0] RST_WORD = 16'h0000;

	localparam int CLK_PERIOD_NS = 8;
	localparam int INIT_TIME_NS = 1000;
	localparam logic [7:0] INIT_CYCLES = 8'((INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	function automatic logic value_ok(input logic [2:0] sig, input logic dt, input logic signed [15:0] mn,
		input logic signed [15:0] mx, input logic signed [15:0] v);
		if (dt == DT_OPTIONAL)
			return (v >= mn) && (v <= mx);
		if (sig == SIG_PM10V)
			return (v >= BIN_BIP_MIN) && (v <= BIN_BIP_MAX);
		return (v >= BIN_UNI_MIN) && (v <= BIN_UNI_MAX);
	endfunction

	function automatic logic cfg_ok(input logic [2:0] sig, input logic dt, input logic signed [15:0] mn,
		input logic signed [15:0] mx);
		return (sig <= SIG_4_20MA) && ((dt == DT_BINARY) || (mn <= mx));
	endfunction

endpackage

// >>> ctl_scan_model.sv
module ctl_scan_model
#(
	parameter int SCAN_LEN = 32
)
(
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [2:0] relay_req_i,
	input wire logic [2:0] ctl_relay_clr_i,
	output logic scan_end_o,
	output logic [2:0] ctl_relay_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] cnt_r;

	// Relays are levels owned by the controller; only the clear pulse drops them
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			cnt_r <= 8'h00;
			scan_end_o <= 1'b0;
			ctl_relay_o <= 3'h0;
		end
		else
		begin
			cnt_r <= (cnt_r == 8'(SCAN_LEN - 1)) ? 8'h00 : cnt_r + 8'h01;
			scan_end_o <= (cnt_r == 8'(SCAN_LEN - 1));
			ctl_relay_o <= (ctl_relay_o & ~ctl_relay_clr_i) | relay_req_i;
		end
	end
endmodule

// >>> test_analog_output_param_control.sv
`define CHK(nm, exp, got) \
	begin \
		n_compared++; \
		if ((got) !== (exp)) \
		begin \
			$display("Error %s: expected %h, seen %h", nm, exp, got); \
			n_fail++; \
		end \
	end

module test_analog_output_param_control
	import ao_param_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic run_i = 1'b0;
	logic scan_end_i;
	logic hold_i = 1'b0;
	logic use_reg_i = 1'b0;
	logic prog_upd_i = 1'b0;
	logic sum_err_i = 1'b0;
	logic fault_i = 1'b0;
	logic [2:0] relay_req = 3'h0;
	logic [2:0] ctl_relay_i;
	logic [2:0] ctl_relay_clr_o;
	logic [3:0] dreg_addr_i = 4'h0;
	logic dreg_wr_i = 1'b0;
	logic [15:0] dreg_wdata_i = 16'h0000;
	logic [15:0] dreg_rdata_o;
	logic [3:0] words_used_o;
	logic [NUM_CH-1:0][15:0] ao_value_o;
	logic [NUM_CH-1:0][2:0] ao_range_o;
	logic [NUM_CH-1:0] ao_conv_en_o;
	int n_fail = 0;
	int n_compared = 0;

	always #4 clk_sys_i = ~clk_sys_i;

	ctl_scan_model u_ctl (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .relay_req_i(relay_req),
		.ctl_relay_clr_i(ctl_relay_clr_o), .scan_end_o(scan_end_i), .ctl_relay_o(ctl_relay_i));

	analog_output_param_control u_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .run_i(run_i),
		.scan_end_i(scan_end_i), .hold_outputs_when_stopped_flag_i(hold_i), .use_reg_params_i(use_reg_i),
		.user_prog_update_i(prog_upd_i), .keep_sum_err_i(sum_err_i), .supply_fault_i(fault_i),
		.ctl_relay_i(ctl_relay_i), .ctl_relay_clr_o(ctl_relay_clr_o), .dreg_addr_i(dreg_addr_i),
		.dreg_wr_i(dreg_wr_i), .dreg_wdata_i(dreg_wdata_i), .dreg_rdata_o(dreg_rdata_o),
		.words_used_o(words_used_o), .init_sig_i({SIG_UNUSED, SIG_0_10V}), .init_dt_i(2'h0),
		.init_min_i(32'h00000000), .init_max_i(32'h00000000), .ao_value_o(ao_value_o),
		.ao_range_o(ao_range_o), .ao_conv_en_o(ao_conv_en_o));

	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic scan();
		for (int k = 0; k < 100; k++)
		begin
			@(posedge clk_sys_i);
			if (scan_end_i === 1'b1)
				break;
		end
		#1;
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys_i);
		dreg_addr_i <= a;
		dreg_wdata_i <= d;
		dreg_wr_i <= 1'b1;
		@(posedge clk_sys_i);
		dreg_wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [15:0] exp);
		@(posedge clk_sys_i);
		dreg_addr_i <= a;
		@(posedge clk_sys_i);
		#1;
		`CHK("dreg_rdata", exp, dreg_rdata_o);
	endtask

	task automatic relay(input logic [2:0] bits, input logic [2:0] exp);
		@(posedge clk_sys_i);
		relay_req <= bits;
		@(posedge clk_sys_i);
		relay_req <= 3'h0;
		scan();
		`CHK("relay_clr", exp, ctl_relay_clr_o);
	endtask

	task automatic settle();
		repeat (INIT_CYCLES + 8) @(posedge clk_sys_i);
		scan();
	endtask

	task automatic stop_run(input logic hold);
		@(posedge clk_sys_i);
		hold_i <= hold;
		run_i <= 1'b0;
		scan();
		repeat (2) @(posedge clk_sys_i);
		#1;
	endtask

	task automatic t_reset();
		`CHK("words_used", 4'h4, words_used_o);
		`CHK("range0", SIG_0_10V, ao_range_o[0]);
		`CHK("value0", 16'h0000, ao_value_o[0]);
	endtask

	task automatic t_binary();
		@(posedge clk_sys_i);
		run_i <= 1'b1;
		scan();
		rd(4'h1, STAT_INITIALIZING);
		settle();
		`CHK("conv_en", 2'h1, ao_conv_en_o);
		`CHK("range1", SIG_0_10V, ao_range_o[1]);
		rd(4'h1, STAT_OK);
		wr(4'h0, 16'h0064);
		scan();
		`CHK("value0", 16'h0064, ao_value_o[0]);
		wr(4'h0, 16'h1000);
		scan();
		`CHK("value0", 16'h0064, ao_value_o[0]);
		rd(4'h1, STAT_PARAM_ERR);
		wr(4'h0, 16'h0FFF);
		wr(4'h1, 16'h0003);
		scan();
		`CHK("value0", 16'h0FFF, ao_value_o[0]);
		`CHK("value1", 16'h0000, ao_value_o[1]);
		rd(4'h1, STAT_OK);
		rd(4'h5, 16'h0000);
	endtask

	task automatic t_stop();
		stop_run(1'b1);
		`CHK("value0", 16'h0FFF, ao_value_o[0]);
		stop_run(1'b0);
		`CHK("value0", 16'h0000, ao_value_o[0]);
		@(posedge clk_sys_i);
		run_i <= 1'b1;
		fault_i <= 1'b1;
		scan();
		settle();
		rd(4'h1, STAT_SUPPLY_FAULT);
		@(posedge clk_sys_i);
		fault_i <= 1'b0;
		scan();
		scan();
		rd(4'h1, STAT_OK);
	endtask

	task automatic t_regs();
		@(posedge clk_sys_i);
		use_reg_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		#1;
		`CHK("words_used", 4'hC, words_used_o);
		for (int s = 1; s <= 4; s++)
		begin
			wr(4'h4, 16'(s));
			relay(3'h4, 3'h4);
			@(posedge clk_sys_i);
			#1;
			`CHK("range0", 3'(s), ao_range_o[0]);
			settle();
		end
		wr(4'h8, 16'(SIG_PM10V));
		wr(4'hA, 16'h0005);
		rd(4'hA, 16'h0000);
		wr(4'h9, 16'(DT_OPTIONAL));
		wr(4'hA, 16'hFF9C);
		wr(4'hB, 16'h012C);
		rd(4'hA, 16'hFF9C);
		relay(3'h4, 3'h4);
		settle();
		wr(4'h2, 16'h0190);
		scan();
		rd(4'h3, STAT_PARAM_ERR);
		wr(4'h2, 16'h012C);
		scan();
		`CHK("value1", 16'h012C, ao_value_o[1]);
		stop_run(1'b0);
		`CHK("value1", 16'h0064, ao_value_o[1]);
		wr(4'h8, 16'(SIG_0_20MA));
		@(posedge clk_sys_i);
		run_i <= 1'b1;
		scan();
		settle();
		`CHK("range1", SIG_0_20MA, ao_range_o[1]);
	endtask

	task automatic t_relays();
		wr(4'h4, 16'(SIG_0_10V));
		relay(3'h1, 3'h1);
		rd(4'h4, 16'(SIG_4_20MA));
		relay(3'h2, 3'h2);
		rd(4'h4, 16'(SIG_0_10V));
		wr(4'h4, 16'(SIG_PM10V));
		relay(3'h7, 3'h7);
		@(posedge clk_sys_i);
		#1;
		`CHK("range0", SIG_0_10V, ao_range_o[0]);
		settle();
		`CHK("conv_en", 2'h1, ao_conv_en_o);
		wr(4'h4, 16'(SIG_0_20MA));
		@(posedge clk_sys_i);
		prog_upd_i <= 1'b1;
		@(posedge clk_sys_i);
		prog_upd_i <= 1'b0;
		rd(4'h4, 16'(SIG_0_10V));
		wr(4'h4, 16'(SIG_0_20MA));
		@(posedge clk_sys_i);
		sum_err_i <= 1'b1;
		@(posedge clk_sys_i);
		sum_err_i <= 1'b0;
		rd(4'h4, 16'(SIG_0_10V));
		@(posedge clk_sys_i);
		use_reg_i <= 1'b0;
		relay(3'h4, 3'h0);
	endtask

	initial
	begin
		repeat (2) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		@(posedge clk_sys_i);
		#1;
		t_reset();
		t_binary();
		t_stop();
		t_regs();
		t_relays();
		wrap_up();
	end

	// Generous bound over a test of about ten init phases plus some thirty scans
	initial
	begin
		repeat (30000) @(posedge clk_sys_i);
		n_fail++;
		wrap_up();
	end
endmodule
